/* File: hdl/setpoint_pkg.sv */
`default_nettype none
package setpoint_pkg;
  // speed values are signed rpm, 16 bits
  localparam int SPD_W          = 16;
  localparam int TIME_W         = 16;   // ramp times in ms
  localparam int FREQ_W         = 16;   // output frequency in 0.01 Hz units
  localparam int VOLT_W         = 16;
  localparam int WORD_IDX_W     = 3;
  localparam int NUM_WORDS      = 8;
  // control tick period
  localparam int CLK_MHZ        = 100;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
  localparam int SEC_PER_MIN    = 60;
  localparam int FREQ_SCALE     = 100;
  // source selection codes
  localparam logic [1:0] SRC_SERIAL   = 2'h0;
  localparam logic [1:0] SRC_FIELDBUS = 2'h1;
  localparam logic [1:0] SRC_DIRECT   = 2'h2;
  // characteristic codes
  localparam logic [2:0] VF_LINEAR    = 3'h0;
  localparam logic [2:0] VF_FCC       = 3'h1;
  localparam logic [2:0] VF_SQUARE    = 3'h2;
  localparam logic [2:0] VF_USER      = 3'h3;
  typedef enum {RG_OFF, RG_RUN, RG_STOP, RG_QSTOP} ramp_state_t;
endpackage : setpoint_pkg
`default_nettype wire

/* File: hdl/vf_if.sv */
`timescale 1ns/1ps
`default_nettype none
// carries the ramped speed into the characteristic stage
interface vf_if;
  import setpoint_pkg::*;
  logic                     tick;
  logic signed [SPD_W-1:0]  speed;
  logic [SPD_W-1:0]         max_speed;
  logic [2:0]               vf_sel;
  logic [3:0]               pole_pairs;
  logic [15:0]              rs_value;
  logic [15:0]              user_slope;
  logic [FREQ_W-1:0]        freq;
  logic [VOLT_W-1:0]        volt;
  modport ramp (output tick, speed, max_speed, vf_sel, pole_pairs, rs_value, user_slope,
                input freq, volt);
  modport calc (input tick, speed, max_speed, vf_sel, pole_pairs, rs_value, user_slope,
                output freq, volt);
endinterface : vf_if
`default_nettype wire

/* File: hdl/vf_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module vf_calc
  import setpoint_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // link from ramp
  vf_if.calc        vf
);
  ////////////////////////////////////////////////////////////////////////
  logic [SPD_W-1:0]  mag;
  logic [35:0]       fprod;
  logic [FREQ_W-1:0] freq_next;
  logic [31:0]       ratio;
  logic [31:0]       ratio_c;
  logic [31:0]       sq;
  logic [VOLT_W-1:0] volt_base;
  logic [VOLT_W-1:0] volt_next;
  logic [FREQ_W-1:0] freq_reg;
  logic [VOLT_W-1:0] volt_reg;

  // f = n * pole pairs / 60, in 0.01 Hz
  assign mag       = vf.speed[SPD_W-1] ? SPD_W'(-vf.speed) : SPD_W'(vf.speed);
  assign fprod     = 36'(mag) * 36'(vf.pole_pairs) * 36'(FREQ_SCALE);     // RQ13
  assign freq_next = FREQ_W'(fprod / 36'(SEC_PER_MIN));                   // RQ13
  // voltage as fraction of full scale, ratio is speed/max in 16-bit
  assign ratio     = (vf.max_speed == '0) ? 32'h0 : ({16'h0, mag} << 16) / {16'h0, vf.max_speed};
  // clamp first so no product below can overflow if the maximum is lowered
  assign ratio_c   = (ratio > 32'hffff) ? 32'hffff : ratio;
  assign sq        = ratio_c * ratio_c;
  // square law gives less voltage at part load, so less loss
  assign volt_base = (vf.vf_sel == VF_SQUARE) ? VOLT_W'(sq >> 16) :                  // RQ14
                     (vf.vf_sel == VF_USER)   ? VOLT_W'((ratio_c * 32'(vf.user_slope)) >> 16) : // RQ15
                     VOLT_W'(ratio_c);                                              // RQ14
  // stator drop term added only for flux current compensation
  assign volt_next = (vf.vf_sel == VF_FCC) ? VOLT_W'(volt_base + vf.rs_value) : volt_base; // RQ15 RQ16

  // results update once per control tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_reg <= '0;
      volt_reg <= '0;
    end else if (vf.tick) begin
      freq_reg <= freq_next;
      volt_reg <= volt_next;
    end
  end
  assign vf.freq = freq_reg;
  assign vf.volt = volt_reg;

  a_fcc_adds_rs: assert property (@(posedge clk) disable iff (rst) // RQ16
    vf.tick && vf.vf_sel == VF_FCC |=> vf.volt == $past(volt_base) + $past(vf.rs_value))
    else $error("fcc voltage lacks stator term");
endmodule : vf_calc
`default_nettype wire

/* File: hdl/speed_setpoint_ramp_vf.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: switch-on ramps at least to minimum speed
// RQ2: minimum speed applies in both directions
// RQ3: setpoint magnitude clamped to maximum speed
// RQ4: overspeed raises fault indication
// RQ5: ramp-up time spans zero to maximum
// RQ6: ramp-down time spans maximum to standstill
// RQ7: ramp-up and ramp-down set separately
// RQ8: on/off uses normal ramp times
// RQ9: quick stop uses its own time
// RQ10: torque limit may stretch the ramp
// RQ11: rounding lengthens normal ramps
// RQ12: quick stop ramp is never rounded
// RQ13: frequency equals rpm times pole pairs over 60
// RQ14: select 0 linear, 2 square law
// RQ15: select 1 flux compensation, 3 user
// RQ16: flux mode adds stator resistance term
// RQ17: controller avoids vector control beyond limits
// RQ18: serial or fieldbus words feed the setpoint
// RQ19: per tick step bounded by max over time
module speed_setpoint_ramp_vf
  import setpoint_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)(
  // clock and reset
  input  wire logic                        CLOCK,
  input  wire logic                        SYS_RST,
  // setpoint sources
  input  wire logic [1:0]                  MAIN_SETPOINT_SOURCE,
  input  wire logic [WORD_IDX_W-1:0]       WORD_INDEX,
  input  wire logic [NUM_WORDS*SPD_W-1:0]  SERIAL_RECEIVE_WORDS,
  input  wire logic [NUM_WORDS*SPD_W-1:0]  FIELDBUS_RECEIVE_WORDS,
  input  wire logic signed [SPD_W-1:0]     DIRECT_SETPOINT,
  // limits and ramp settings
  input  wire logic [SPD_W-1:0]            MINIMUM_SPEED_SETTING,
  input  wire logic [SPD_W-1:0]            MAXIMUM_SPEED_SETTING,
  input  wire logic [TIME_W-1:0]           RAMP_UP_TIME,
  input  wire logic [TIME_W-1:0]           RAMP_DOWN_TIME,
  input  wire logic [TIME_W-1:0]           QUICK_STOP_RAMP_TIME,
  input  wire logic [TIME_W-1:0]           RAMP_ROUNDING_FIRST_SETTING,
  input  wire logic                        ROUNDING_ENABLE,
  // commands
  input  wire logic                        RUN_COMMAND,
  input  wire logic                        NORMAL_STOP_COMMAND,
  input  wire logic                        QUICK_STOP_COMMAND,
  input  wire logic                        TORQUE_LIMIT,
  // motor data
  input  wire logic signed [SPD_W-1:0]     ACTUAL_SPEED,
  input  wire logic [3:0]                  POLE_PAIRS,
  input  wire logic [2:0]                  VF_CHARACTERISTIC_SELECT,
  input  wire logic [15:0]                 STATOR_RESISTANCE_VALUE,
  input  wire logic [15:0]                 USER_VF_SLOPE,
  // results
  output logic signed [SPD_W-1:0]          RAMP_SPEED,
  output logic [FREQ_W-1:0]                OUTPUT_FREQUENCY,
  output logic [FREQ_W-1:0]                MAX_FREQUENCY,
  output logic [VOLT_W-1:0]                OUTPUT_VOLTAGE,
  output logic                             OVERSPEED_FAULT,
  output logic                             MOTOR_RUNNING
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [SPD_W-1:0] absval(input logic signed [SPD_W-1:0] v);
    absval = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
  endfunction : absval

  // step per tick: max speed * tick time / ramp time (ms)
  function automatic logic [SPD_W-1:0] step_of(input logic [SPD_W-1:0] mx,
                                                input logic [TIME_W-1:0] t_ms);
    logic [31:0] q;
    q = 32'h0;
    if (t_ms == '0) q = 32'(mx);
    else q = (32'(mx) * 32'(TICK_US / 1000)) / 32'(t_ms);
    step_of = (q == 32'h0) ? SPD_W'(1) : (q > 32'(mx) ? mx : SPD_W'(q));
  endfunction : step_of

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers for pin-level commands
  logic [1:0] run_s, nstop_s, qstop_s, tq_s;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      run_s   <= 2'h0;
      nstop_s <= 2'h0;
      qstop_s <= 2'h0;
      tq_s    <= 2'h0;
    end else begin
      run_s   <= {run_s[0], RUN_COMMAND};
      nstop_s <= {nstop_s[0], NORMAL_STOP_COMMAND};
      qstop_s <= {qstop_s[0], QUICK_STOP_COMMAND};
      tq_s    <= {tq_s[0], TORQUE_LIMIT};
    end
  end
  wire run_c   = run_s[1];
  wire nstop_c = nstop_s[1];
  wire qstop_c = qstop_s[1];
  wire tq_c    = tq_s[1];

  // measured speed arrives from the drive side; a word torn during a change
  // lasts one cycle only, and the fault it feeds is a plain level
  logic signed [SPD_W-1:0] act_meta_reg;
  logic signed [SPD_W-1:0] act_spd_reg;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      act_meta_reg <= '0;
      act_spd_reg  <= '0;
    end else begin
      act_meta_reg <= ACTUAL_SPEED;
      act_spd_reg  <= act_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control tick divider
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= (tick_cnt_reg == 32'(TICK_CYC - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection and limiting
  wire signed [SPD_W-1:0] serial_w = SERIAL_RECEIVE_WORDS[WORD_INDEX*SPD_W +: SPD_W];   // RQ18
  wire signed [SPD_W-1:0] fbus_w   = FIELDBUS_RECEIVE_WORDS[WORD_INDEX*SPD_W +: SPD_W]; // RQ18
  wire signed [SPD_W-1:0] src_w    = (MAIN_SETPOINT_SOURCE == SRC_SERIAL)   ? serial_w : // RQ18
                                     (MAIN_SETPOINT_SOURCE == SRC_FIELDBUS) ? fbus_w   :
                                     DIRECT_SETPOINT;
  wire              src_neg  = src_w[SPD_W-1];
  wire [SPD_W-1:0]  src_mag  = absval(src_w);
  // min first then max, so max wins if settings cross
  wire [SPD_W-1:0]  mag_lo   = (src_mag < MINIMUM_SPEED_SETTING) ? MINIMUM_SPEED_SETTING
                                                                 : src_mag; // RQ1 RQ2
  wire [SPD_W-1:0]  mag_lim  = (mag_lo > MAXIMUM_SPEED_SETTING) ? MAXIMUM_SPEED_SETTING
                                                                : mag_lo;   // RQ3
  wire signed [SPD_W-1:0] lim_sp = src_neg ? SPD_W'(-mag_lim) : SPD_W'(mag_lim); // RQ2

  ////////////////////////////////////////////////////////////////////////
  // ramp state machine; a run request is refused while either stop is high,
  // and quick stop holds until standstill, so a stop cannot be lost to a
  // run request that arrives on the same tick
  ramp_state_t state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RG_OFF:   if (run_c && !nstop_c && !qstop_c) state_next = RG_RUN;
      RG_RUN:   if (qstop_c) state_next = RG_QSTOP;
                else if (nstop_c || !run_c) state_next = RG_STOP;
      RG_STOP:  if (qstop_c) state_next = RG_QSTOP;
                else if (run_c && !nstop_c) state_next = RG_RUN;
                else if (RAMP_SPEED == '0) state_next = RG_OFF;
      RG_QSTOP: if (RAMP_SPEED == '0) state_next = RG_OFF;
      default:  state_next = RG_OFF;
    endcase
  end

  // target and ramp time selection
  wire signed [SPD_W-1:0] target = (state_reg == RG_RUN) ? lim_sp : '0;       // RQ8
  wire [SPD_W-1:0] cur_mag = absval(RAMP_SPEED);
  wire [SPD_W-1:0] tgt_mag = absval(target);
  // rising magnitude in same direction means accelerating
  wire accel   = (tgt_mag > cur_mag) && (RAMP_SPEED == '0 || target[SPD_W-1] == RAMP_SPEED[SPD_W-1]);
  wire round_on = ROUNDING_ENABLE && state_reg != RG_QSTOP;                   // RQ12
  wire [TIME_W-1:0] base_t = (state_reg == RG_QSTOP) ? QUICK_STOP_RAMP_TIME : // RQ9 RQ12
                             accel ? RAMP_UP_TIME : RAMP_DOWN_TIME;           // RQ5 RQ6 RQ7
  // rounding simply stretches the ramp by the rounding time
  wire [16:0] sum_t = {1'b0, base_t} + (round_on ? {1'b0, RAMP_ROUNDING_FIRST_SETTING} : 17'h0); // RQ11
  wire [TIME_W-1:0] act_t = sum_t[16] ? {TIME_W{1'b1}} : sum_t[TIME_W-1:0];
  wire [SPD_W-1:0] step = step_of(MAXIMUM_SPEED_SETTING, act_t);             // RQ19
  wire signed [SPD_W:0] diff = {target[SPD_W-1], target} - {RAMP_SPEED[SPD_W-1], RAMP_SPEED};
  wire signed [SPD_W:0] stp  = {1'b0, step};
  // torque limit freezes the ramp, so real ramp time exceeds the setting
  wire signed [SPD_W-1:0] ramp_next =
      tq_c            ? RAMP_SPEED :                                          // RQ10
      (diff > stp)    ? SPD_W'(RAMP_SPEED + step) :                           // RQ19
      (diff < -stp)   ? SPD_W'(RAMP_SPEED - step) : target;                   // RQ19

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg  <= RG_OFF;
      RAMP_SPEED <= '0;
    end else if (tick_reg) begin
      state_reg  <= state_next;
      RAMP_SPEED <= ramp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overspeed and status flags
  wire over = absval(act_spd_reg) > MAXIMUM_SPEED_SETTING;                    // RQ4
  logic [35:0] fmax_prod;
  assign fmax_prod = 36'(MAXIMUM_SPEED_SETTING) * 36'(POLE_PAIRS) * 36'(FREQ_SCALE); // RQ13
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OVERSPEED_FAULT <= 1'b0;
      MOTOR_RUNNING   <= 1'b0;
      MAX_FREQUENCY   <= '0;
    end else begin
      OVERSPEED_FAULT <= over;                                                // RQ4
      MOTOR_RUNNING   <= (state_reg != RG_OFF);
      MAX_FREQUENCY   <= FREQ_W'(fmax_prod / 36'(SEC_PER_MIN));               // RQ13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // characteristic stage
  vf_if vfl ();
  assign vfl.tick       = tick_reg;
  assign vfl.speed      = RAMP_SPEED;
  assign vfl.max_speed  = MAXIMUM_SPEED_SETTING;
  assign vfl.vf_sel     = VF_CHARACTERISTIC_SELECT;
  assign vfl.pole_pairs = POLE_PAIRS;
  assign vfl.rs_value   = STATOR_RESISTANCE_VALUE;
  assign vfl.user_slope = USER_VF_SLOPE;
  vf_calc u_calc (
    .clk (CLOCK),
    .rst (SYS_RST),
    .vf  (vfl.calc)
  );
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OUTPUT_FREQUENCY <= '0;
      OUTPUT_VOLTAGE   <= '0;
    end else begin
      OUTPUT_FREQUENCY <= vfl.freq;
      OUTPUT_VOLTAGE   <= vfl.volt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // limits and fault flag
  a_max_clamp: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ3
    absval(RAMP_SPEED) <= MAXIMUM_SPEED_SETTING || !$stable(MAXIMUM_SPEED_SETTING))
    else $error("ramp speed above maximum");
  a_min_speed: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ1
    state_reg == RG_RUN && MINIMUM_SPEED_SETTING <= MAXIMUM_SPEED_SETTING
    |-> absval(lim_sp) >= MINIMUM_SPEED_SETTING)
    else $error("setpoint below minimum");
  a_min_reverse: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ2
    state_reg == RG_RUN && src_neg && MINIMUM_SPEED_SETTING != '0 &&
    MINIMUM_SPEED_SETTING <= MAXIMUM_SPEED_SETTING
    |-> target[SPD_W-1] && absval(target) >= MINIMUM_SPEED_SETTING)
    else $error("reverse setpoint below minimum");
  a_overspeed_flag: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ4
    over |=> OVERSPEED_FAULT)
    else $error("overspeed not flagged");
  a_overspeed_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ4
    !over |=> !OVERSPEED_FAULT)
    else $error("overspeed flagged without cause");

  // ramp rate and torque limit
  a_step_bound: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ19
    tick_reg && !tq_c |=> absval(SPD_W'(RAMP_SPEED - $past(RAMP_SPEED))) <= $past(step))
    else $error("ramp step too large");
  a_torque_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ10
    tick_reg && tq_c |=> $stable(RAMP_SPEED))
    else $error("ramp moved under torque limit");

  // stop paths and ramp time choice
  a_qstop_wins: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    tick_reg && qstop_c && (state_reg == RG_RUN || state_reg == RG_STOP)
    |=> state_reg == RG_QSTOP)
    else $error("quick stop not taken");
  a_qstop_time: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ9
    state_reg == RG_QSTOP |-> act_t == QUICK_STOP_RAMP_TIME)
    else $error("quick stop ramp time wrong");
  a_qstop_unround: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ12
    state_reg == RG_QSTOP && ROUNDING_ENABLE |-> act_t == QUICK_STOP_RAMP_TIME)
    else $error("quick stop ramp was rounded");
  a_up_time: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ5
    state_reg == RG_RUN && accel && !ROUNDING_ENABLE |-> act_t == RAMP_UP_TIME)
    else $error("ramp up time not used");
  a_down_time: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ6
    state_reg == RG_STOP && !ROUNDING_ENABLE |-> act_t == RAMP_DOWN_TIME)
    else $error("ramp down time not used");
  a_round_stretch: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ11
    state_reg == RG_RUN && accel && ROUNDING_ENABLE &&
    17'(RAMP_UP_TIME) + 17'(RAMP_ROUNDING_FIRST_SETTING) < 17'h10000
    |-> act_t == TIME_W'(RAMP_UP_TIME + RAMP_ROUNDING_FIRST_SETTING))
    else $error("rounding did not stretch ramp");
  a_refuse_run: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ8
    tick_reg && state_reg == RG_OFF && (nstop_c || qstop_c) |=> state_reg == RG_OFF)
    else $error("run taken while stop high");

  // frequency scaling
  a_fmax_calc: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RQ13
    $stable(MAXIMUM_SPEED_SETTING) && $stable(POLE_PAIRS) |=> MAX_FREQUENCY ==
    FREQ_W'(fmax_prod / 36'(SEC_PER_MIN)))
    else $error("max frequency wrong");

  // main scenarios reached
  c_run: cover property (@(posedge CLOCK) state_reg == RG_OFF ##1 state_reg == RG_RUN);
  c_qstop: cover property (@(posedge CLOCK) state_reg == RG_QSTOP);
  c_over: cover property (@(posedge CLOCK) OVERSPEED_FAULT);
  c_round: cover property (@(posedge CLOCK) state_reg == RG_RUN && accel && ROUNDING_ENABLE);
  c_torque: cover property (@(posedge CLOCK) tick_reg && tq_c && state_reg == RG_RUN);
endmodule : speed_setpoint_ramp_vf
`default_nettype wire

/* File: dv/fieldbus_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module fieldbus_controller
  import setpoint_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // word writes from the sequence
  input  wire logic                     wr_en,
  input  wire logic                     wr_fb,
  input  wire logic [WORD_IDX_W-1:0]    wr_idx,
  input  wire logic signed [SPD_W-1:0]  wr_val,
  input  wire logic [1:0]               char_req,
  // towards the inverter
  output logic [NUM_WORDS*SPD_W-1:0]    serial_words,
  output logic [NUM_WORDS*SPD_W-1:0]    fieldbus_words,
  output logic [2:0]                    char_sel
);
  //////////////////////////////////////////////////////////////////////////////
  // only the four v/f codes are asked for, so vector control is never chosen
  assign char_sel = {1'b0, char_req};
  // receive words refresh on the clock; untouched words hold a busy pattern
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_words   <= {NUM_WORDS{16'ha5c3}};
      fieldbus_words <= {NUM_WORDS{16'h3c5a}};
    end else if (wr_en && wr_fb) begin
      fieldbus_words[wr_idx*SPD_W +: SPD_W] <= wr_val;
    end else if (wr_en) begin
      serial_words[wr_idx*SPD_W +: SPD_W] <= wr_val;
    end
  end
endmodule : fieldbus_controller
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import setpoint_pkg::*;
  localparam int TC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] src, char_req;
  logic [2:0] idx, wr_idx, csel;
  logic signed [15:0] direct, actual, wr_val, rspd;
  logic [15:0] vmin, vmax, t_up, t_dn, t_qs, t_rnd, rs, slope, freq, fmax, volt;
  logic rnd_en, run, stop, qstop, torque, wr_en, wr_fb, ovs, running;
  logic [3:0] pp;
  logic [127:0] sw, fw;
  int bad_count = 0;
  int checked = 0;
  //////////////////////////////////////////////////////////////////////////////
  // free running clock, 10 ns
  always #5 clk = ~clk;

  speed_setpoint_ramp_vf #(.TICK_CYC(TC)) dut (.CLOCK(clk), .SYS_RST(rst),
    .MAIN_SETPOINT_SOURCE(src), .WORD_INDEX(idx), .SERIAL_RECEIVE_WORDS(sw),
    .FIELDBUS_RECEIVE_WORDS(fw), .DIRECT_SETPOINT(direct), .MINIMUM_SPEED_SETTING(vmin),
    .MAXIMUM_SPEED_SETTING(vmax), .RAMP_UP_TIME(t_up), .RAMP_DOWN_TIME(t_dn),
    .QUICK_STOP_RAMP_TIME(t_qs), .RAMP_ROUNDING_FIRST_SETTING(t_rnd),
    .ROUNDING_ENABLE(rnd_en), .RUN_COMMAND(run), .NORMAL_STOP_COMMAND(stop),
    .QUICK_STOP_COMMAND(qstop), .TORQUE_LIMIT(torque), .ACTUAL_SPEED(actual),
    .POLE_PAIRS(pp), .VF_CHARACTERISTIC_SELECT(csel), .STATOR_RESISTANCE_VALUE(rs),
    .USER_VF_SLOPE(slope), .RAMP_SPEED(rspd), .OUTPUT_FREQUENCY(freq),
    .MAX_FREQUENCY(fmax), .OUTPUT_VOLTAGE(volt), .OVERSPEED_FAULT(ovs),
    .MOTOR_RUNNING(running));

  fieldbus_controller partner (.clk(clk), .rst(rst), .wr_en(wr_en), .wr_fb(wr_fb),
    .wr_idx(wr_idx), .wr_val(wr_val), .char_req(char_req), .serial_words(sw),
    .fieldbus_words(fw), .char_sel(csel));
  //////////////////////////////////////////////////////////////////////////////
  // one compare for everything, sign kept by the 32 bit arguments
  task check(string what, logic signed [31:0] seen, logic signed [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
      bad_count++;
    end
  endtask : check

  // expected ramp step per 1 ms tick: full speed over the active ramp time
  function automatic int exp_step(int mx, int t_ms);
    exp_step = (t_ms == 0) ? mx : (mx / t_ms == 0) ? 1 : mx / t_ms;
  endfunction : exp_step

  // expected frequency in 0.01 Hz from rpm and pole pairs
  function automatic int exp_freq(int rpm, int pairs);
    exp_freq = rpm * pairs * FREQ_SCALE / SEC_PER_MIN;
  endfunction : exp_freq

  task end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // inputs always move 1 ns after the edge
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // bounded wait for the ramp to land on a value
  task settle(logic signed [15:0] exp);
    int k;
    for (k = 0; k < 6000 && rspd !== exp; k++) cyc(1);
    if (k == 6000) begin
      $display("[ERR] settle expected %0d seen %0d", exp, rspd);
      bad_count++;
      end_of_test();
    end
  endtask : settle

  // size of the next ramp move, bounded to 20 ticks
  task step_of(output logic signed [31:0] d);
    logic signed [15:0] v0;
    int k;
    v0 = rspd;
    for (k = 0; k < 200 && rspd === v0; k++) cyc(1);
    if (k == 200) begin
      $display("[ERR] step expected a move seen %0d", rspd);
      bad_count++;
      end_of_test();
    end
    d = rspd - v0;
  endtask : step_of

  // write one receive word; a spare edge keeps the strobe single per step
  task put_word(logic fb, logic [2:0] i, logic signed [15:0] v);
    wr_fb = fb;
    wr_idx = i;
    wr_val = v;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask : put_word
  //////////////////////////////////////////////////////////////////////////////
  // main sequence: ramp timing, stops, characteristic, limits, overspeed
  initial begin
    logic signed [31:0] d;
    int i;
    logic signed [15:0] a;
    logic [15:0] vlin, vsq;
    void'($urandom(32'h264115ee));
    src = SRC_DIRECT; idx = 3'h0; direct = 16'h0; actual = 16'h0; vmin = 16'h0;
    vmax = 16'd1500; t_up = 16'd100; t_dn = 16'd50; t_qs = 16'd25; t_rnd = 16'd100;
    rnd_en = 0; run = 0; stop = 0; qstop = 0; torque = 0; slope = 16'($urandom);
    pp = 4'($urandom_range(15, 1)); rs = 16'($urandom_range(255, 1));
    wr_en = 0; wr_fb = 0; wr_idx = 3'h0; wr_val = 16'h0; char_req = 2'h0;
    cyc(20);
    rst = 1'b0;
    direct = 16'd1500; run = 1'b1;
    step_of(d); check("up_step", d, exp_step(vmax, t_up));
    // frequency follows one tick behind the ramp, then one more register
    settle(1500); cyc(15);
    check("freq", freq, exp_freq(1500, pp));
    check("max_freq", fmax, exp_freq(vmax, pp));
    check("running", running, 1);
    direct = 16'd600;
    step_of(d); check("down_step", d, -exp_step(vmax, t_dn));
    settle(600);
    torque = 1'b1; direct = 16'd1200; cyc(30); a = rspd; cyc(60);
    check("torque_hold", rspd, a);
    torque = 1'b0; rnd_en = 1'b1;
    step_of(d); check("round_step", d, exp_step(vmax, t_up + t_rnd));
    qstop = 1'b1; cyc(25);
    step_of(d); check("qstop_step", d, -exp_step(vmax, t_qs));
    settle(0); cyc(30); check("qstop_off", running, 0);
    qstop = 1'b0; rnd_en = 1'b0; direct = 16'd900; settle(900);
    stop = 1'b1; cyc(25);
    step_of(d); check("stop_step", d, -exp_step(vmax, t_dn));
    settle(0); cyc(30); check("stop_off", running, 0);
    stop = 1'b0; run = 1'b0; cyc(5); run = 1'b1; direct = 16'd750; settle(750);
    // characteristic codes at half speed
    cyc(40); vlin = volt;
    check("lin_volt", vlin, 32'h8000);
    char_req = 2'h2; cyc(40); vsq = volt;
    check("square_volt", vsq, 32'h4000);
    char_req = 2'h1; cyc(40); check("fcc_volt", volt, vlin + rs);
    char_req = 2'h3; cyc(40); check("user_volt", volt, slope >> 1);
    char_req = 2'h0; run = 1'b0; settle(0);
    // minimum and maximum through the receive words
    vmin = 16'd300; i = $urandom_range(7, 0); idx = i[2:0];
    put_word(1'b1, i[2:0], 16'sd10); src = SRC_FIELDBUS; run = 1'b1;
    settle(300); cyc(30); check("min_fwd", rspd, 300);
    put_word(1'b1, i[2:0], -16'sd10);
    settle(-300); cyc(30); check("min_rev", rspd, -300);
    put_word(1'b0, i[2:0], 16'sd3000); src = SRC_SERIAL;
    settle(1500); cyc(30); check("max_fwd", rspd, 1500);
    put_word(1'b0, i[2:0], -16'sd3000);
    settle(-1500); cyc(30); check("max_rev", rspd, -1500);
    // overspeed with edge cases first, then random speeds
    for (i = 0; i < 24; i++) begin
      a = (i == 0) ? 16'sd1500 : (i == 1) ? 16'sd1501 : (i == 2) ? -16'sd1501 :
          16'($urandom_range(6000)) - 16'sd3000;
      actual = a;
      cyc(3);
      check("overspeed", ovs, (a > 1500 || a < -1500));
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
